// ### hw/supply_monitor_ctrl.sv
// Purpose: control logic of the supply voltage monitor
// Assumes: classic Wishbone, comparator output asynchronous
// Notes:   one-cycle ack; interrupt status write-one-to-clear
`timescale 1ns/10ps
module supply_monitor_ctrl #(
    parameter int READY_CYCLES = supply_monitor_pkg::READY_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        cmp_below_async,
    output logic             cmp_power_on,
    output logic      [3:0]  threshold_sel,
    output logic             monitor_irq,
    output logic             irq_o
);
    logic                                   en_r;
    logic                                   en_nxt;
    logic                                   ie_r;
    logic                                   ie_nxt;
    logic                                   uv_r;
    logic                                   uv_nxt;
    logic                                   stop_r;
    logic                                   stop_nxt;
    logic [supply_monitor_pkg::TH_W-1:0]    th_r;
    logic [supply_monitor_pkg::TH_W-1:0]    th_nxt;
    logic [supply_monitor_pkg::EVT_W-1:0]   ists_r;
    logic [supply_monitor_pkg::EVT_W-1:0]   ists_nxt;
    logic [supply_monitor_pkg::EVT_W-1:0]   imsk_r;
    logic [supply_monitor_pkg::EVT_W-1:0]   imsk_nxt;
    logic [supply_monitor_pkg::EVT_W-1:0]   evt;
    logic                                   ack_r;
    logic                                   ack_nxt;
    logic                                   err_r;
    logic                                   err_nxt;
    logic [31:0]                            rdat_r;
    logic [31:0]                            rdat_nxt;
    logic                                   mirq_r;
    logic                                   mirq_nxt;
    logic                                   irq_r;
    logic                                   irq_nxt;
    logic                                   rdy_prev_r;
    logic                                   below_sync;
    logic                                   ready;
    logic                                   req;
    logic                                   wr_ctrl;
    logic                                   wr_sts;
    logic                                   wr_msk;
    logic                                   below_live;

    // ==========================================================
    // address decode helper, used by reads and writes
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
        hit = (adr[7:2] == reg_adr[7:2]);
    endfunction

    // ==========================================================
    // comparator synchroniser and power-up timer
    level_sync u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in (cmp_below_async),
        .sync_out (below_sync)
    );

    ready_timer #(
        .DELAY (READY_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .run      (en_r),
        .ready    (ready)
    );

    // comparison only counts once the monitor is up
    assign below_live = below_sync & ready & en_r;
    assign req        = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign wr_ctrl    = req & wb_we_i & hit(wb_adr_i, supply_monitor_pkg::MON_CTRL_ADDR);
    assign wr_sts     = req & wb_we_i & hit(wb_adr_i, supply_monitor_pkg::IRQ_STATUS_ADDR);
    assign wr_msk     = req & wb_we_i & hit(wb_adr_i, supply_monitor_pkg::IRQ_MASK_ADDR);
    assign evt        = {ready & ~rdy_prev_r, below_live};

    // ==========================================================
    // control register next values
    always_comb begin
        en_nxt   = en_r;
        ie_nxt   = ie_r;
        uv_nxt   = uv_r;
        stop_nxt = stop_r;
        th_nxt   = th_r;
        if (wr_ctrl && wb_sel_i[0]) begin
            en_nxt   = wb_dat_i[supply_monitor_pkg::EN_BIT];
            ie_nxt   = wb_dat_i[supply_monitor_pkg::IE_BIT];
            uv_nxt   = wb_dat_i[supply_monitor_pkg::UV_BIT];
            stop_nxt = wb_dat_i[supply_monitor_pkg::STOP_BIT];
        end
        if (wr_ctrl && wb_sel_i[1] && !en_r) begin
            th_nxt = wb_dat_i[supply_monitor_pkg::TH_MSB:supply_monitor_pkg::TH_LSB];
        end
        // hardware set wins over a software clear
        if (below_live) begin
            uv_nxt = 1'b1;
        end
    end

    // ==========================================================
    // interrupt status and mask next values
    always_comb begin
        ists_nxt = ists_r;
        imsk_nxt = imsk_r;
        if (wr_sts && wb_sel_i[0]) begin
            ists_nxt = ists_r & ~wb_dat_i[supply_monitor_pkg::EVT_W-1:0];
        end
        ists_nxt = ists_nxt | evt;
        if (wr_msk && wb_sel_i[0]) begin
            imsk_nxt = wb_dat_i[supply_monitor_pkg::EVT_W-1:0];
        end
    end

    // ==========================================================
    // bus answer and outputs
    always_comb begin
        ack_nxt  = 1'b0;
        err_nxt  = 1'b0;
        rdat_nxt = rdat_r;
        mirq_nxt = uv_nxt & ie_nxt;
        irq_nxt  = |(ists_nxt & imsk_nxt);
        if (req) begin
            rdat_nxt = 32'h0000_0000;
            if (hit(wb_adr_i, supply_monitor_pkg::MON_CTRL_ADDR)) begin
                ack_nxt = 1'b1;
                rdat_nxt[supply_monitor_pkg::TH_MSB:supply_monitor_pkg::TH_LSB] = th_r;
                rdat_nxt[supply_monitor_pkg::STOP_BIT] = stop_r;
                rdat_nxt[supply_monitor_pkg::UV_BIT]   = uv_r;
                rdat_nxt[supply_monitor_pkg::IE_BIT]   = ie_r;
                rdat_nxt[supply_monitor_pkg::RDY_BIT]  = ready & en_r;
                rdat_nxt[supply_monitor_pkg::EN_BIT]   = en_r; // others zero
            end else if (hit(wb_adr_i, supply_monitor_pkg::IRQ_STATUS_ADDR)) begin
                ack_nxt = 1'b1;
                rdat_nxt[supply_monitor_pkg::EVT_W-1:0] = ists_r;
            end else if (hit(wb_adr_i, supply_monitor_pkg::IRQ_MASK_ADDR)) begin
                ack_nxt = 1'b1;
                rdat_nxt[supply_monitor_pkg::EVT_W-1:0] = imsk_r;
            end else begin
                err_nxt = 1'b1;
            end
        end
    end

    // ==========================================================
    // state registers, frozen while clock enable is low
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_r       <= 1'b0;
            ie_r       <= 1'b0;
            uv_r       <= 1'b0;
            stop_r     <= 1'b0;
            th_r       <= supply_monitor_pkg::TH_RESET;
            ists_r     <= '0;
            imsk_r     <= '0;
            ack_r      <= 1'b0;
            err_r      <= 1'b0;
            rdat_r     <= 32'h0000_0000;
            mirq_r     <= 1'b0;
            irq_r      <= 1'b0;
            rdy_prev_r <= 1'b0;
        end else if (clk_en) begin
            en_r       <= en_nxt;
            ie_r       <= ie_nxt;
            uv_r       <= uv_nxt;
            stop_r     <= stop_nxt;
            th_r       <= th_nxt;
            ists_r     <= ists_nxt;
            imsk_r     <= imsk_nxt;
            ack_r      <= ack_nxt;
            err_r      <= err_nxt;
            rdat_r     <= rdat_nxt;
            mirq_r     <= mirq_nxt;
            irq_r      <= irq_nxt;
            rdy_prev_r <= ready;
        end
    end

    // comparator side: threshold code and power select the trip point
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            threshold_sel <= supply_monitor_pkg::TH_RESET;
            cmp_power_on  <= 1'b0;
        end else if (clk_en) begin
            threshold_sel <= th_nxt;
            cmp_power_on  <= en_nxt;
        end
    end

    assign wb_dat_o    = rdat_r;
    assign wb_ack_o    = ack_r;
    assign wb_err_o    = err_r;
    assign monitor_irq = mirq_r;
    assign irq_o       = irq_r;

    // ==========================================================
    // checks
    property p_th_locked;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && en_r) |=> $stable(th_r);
    endproperty
    a_th_locked: assert property (p_th_locked) else $error("threshold changed while on");

    property p_uv_set;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && below_live) |=> uv_r;
    endproperty
    a_uv_set: assert property (p_uv_set) else $error("flag not set when below");

    property p_irq_gate;
        @(posedge core_clk) disable iff (sys_rst)
        (uv_r && ie_r) |-> monitor_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq missing");

    property p_irq_off;
        @(posedge core_clk) disable iff (sys_rst)
        monitor_irq |-> (uv_r && ie_r);
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without cause");

    property p_rdy_off;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && !en_r) |=> !ready;
    endproperty
    a_rdy_off: assert property (p_rdy_off) else $error("ready while off");

    property p_rdy_late;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && $rose(en_r)) |-> !ready [*8];
    endproperty
    a_rdy_late: assert property (p_rdy_late) else $error("ready too early");

    property p_off_power;
        @(posedge core_clk) disable iff (sys_rst)
        !en_r |-> ##1 (!clk_en || !ready);
    endproperty
    a_off_power: assert property (p_off_power) else $error("ready after disable");

    property p_resv;
        @(posedge core_clk) disable iff (sys_rst)
        ack_r |-> (rdat_r[15:12] == 4'h0) && (rdat_r[7:5] == 3'h0);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits nonzero");

    property p_sel_out;
        @(posedge core_clk) disable iff (sys_rst)
        threshold_sel == th_r;
    endproperty
    a_sel_out: assert property (p_sel_out) else $error("comparator code mismatch");

    property p_uv_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && uv_r && !(wr_ctrl && wb_sel_i[0])) |=> uv_r;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("flag cleared by hardware");

    property p_power_out;
        @(posedge core_clk) disable iff (sys_rst)
        cmp_power_on == en_r;
    endproperty
    a_power_out: assert property (p_power_out) else $error("power select mismatch");

    property p_evt_sticky;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && ists_r[supply_monitor_pkg::EVT_UV] && !(wr_sts && wb_sel_i[0]))
            |=> ists_r[supply_monitor_pkg::EVT_UV];
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) else $error("status bit lost");

    property p_rdy_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (clk_en && ready && en_r) |=> ready;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped while on");

    c_uv: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(uv_r));
    c_rdy: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(ready));
    c_irq: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(irq_o));
    c_soft_set: cover property (@(posedge core_clk) disable iff (sys_rst)
        wr_ctrl && wb_sel_i[0] && wb_dat_i[supply_monitor_pkg::UV_BIT]);
endmodule

// ### hw/supply_monitor_pkg.sv
// Purpose: shared constants for the supply monitor control block
// Assumes: 125 MHz core clock, 32-bit classic Wishbone slave
// Notes:   one control register plus an interrupt status/mask pair
package supply_monitor_pkg;

    // ==========================================================
    // register map (byte addresses, index times four)
    localparam logic [3:0]  MON_CTRL_IDX      = 4'h9;
    localparam logic [7:0]  MON_CTRL_ADDR     = {2'h0, MON_CTRL_IDX, 2'h0};
    localparam logic [7:0]  IRQ_STATUS_ADDR   = 8'h40;
    localparam logic [7:0]  IRQ_MASK_ADDR     = 8'h44;
    localparam int          ADDR_W            = 8;

    // ==========================================================
    // control register fields
    localparam int          EN_BIT            = 0;
    localparam int          RDY_BIT           = 1;
    localparam int          IE_BIT            = 2;
    localparam int          UV_BIT            = 3;
    localparam int          STOP_BIT          = 4;
    localparam int          TH_LSB            = 8;
    localparam int          TH_MSB            = 11;
    localparam int          TH_W              = 4;
    localparam logic [3:0]  TH_RESET          = 4'h0;
    localparam logic [15:0] CTRL_RESET        = 16'h0000;

    // ==========================================================
    // trip point in millivolts: base plus code times step
    localparam int          TRIP_BASE_MV      = 2700;
    localparam int          TRIP_STEP_MV      = 100;

    // ==========================================================
    // interrupt status bits
    localparam int          EVT_UV            = 0;
    localparam int          EVT_RDY           = 1;
    localparam int          EVT_W             = 2;

    // ==========================================================
    // power-up time of the comparator
    localparam int          CLK_MHZ           = 125;
    localparam int          READY_DELAY_US    = 20;
    localparam int          READY_CYCLES      = READY_DELAY_US * CLK_MHZ;
    localparam int          CNT_W             = 13;

endpackage

// ### hw/level_sync.sv
// Purpose: two-flop synchroniser for an asynchronous level
// Assumes: single destination clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module level_sync (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // ==========================================================
    // next values
    always_comb begin
        meta_nxt = clk_en ? async_in : meta_r;
        sync_nxt = clk_en ? meta_r : sync_r;
    end

    // two stages
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule

// ### hw/ready_timer.sv
// Purpose: power-up delay counter raising ready after enable
// Assumes: enable held high for the whole delay
// Notes:   dropping enable restarts the count from zero
`timescale 1ns/10ps
module ready_timer #(
    parameter int DELAY = supply_monitor_pkg::READY_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic run,
    output logic      ready
);
    logic [supply_monitor_pkg::CNT_W-1:0] cnt_r;
    logic [supply_monitor_pkg::CNT_W-1:0] cnt_nxt;
    logic                                 rdy_r;
    logic                                 rdy_nxt;

    // ==========================================================
    // count while running, ready at terminal count
    always_comb begin
        cnt_nxt = cnt_r;
        rdy_nxt = rdy_r;
        if (clk_en) begin
            if (!run) begin
                cnt_nxt = '0;
                rdy_nxt = 1'b0;
            end else if (!rdy_r) begin
                if (cnt_r == DELAY[supply_monitor_pkg::CNT_W-1:0] - 1'b1) begin
                    rdy_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
            rdy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign ready = rdy_r;
endmodule

// ### testbench/supply_monitor_ctrl_bench.sv
// Purpose: self-checking bench for the supply monitor control block
// Assumes: one-cycle Wishbone ack, READY_CYCLES shortened to 20
// Notes:   random threshold codes from an lfsr seeded with 37
`timescale 1ns/10ps
module supply_monitor_ctrl_bench;

    // ==========================================================
    // stimulus and observation signals
    localparam int    RDY_CYC = 20;
    localparam int    LIMIT   = 20000;
    logic             core_clk;
    logic             sys_rst;
    logic             wb_cyc_i;
    logic             wb_stb_i;
    logic             wb_we_i;
    logic [7:0]       wb_adr_i;
    logic [31:0]      wb_dat_i;
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o;
    logic             wb_err_o;
    logic             cmp_below_async;
    logic             cmp_power_on;
    logic [3:0]       threshold_sel;
    logic             monitor_irq;
    logic             irq_o;
    int               num_errors;
    int               tests_run;
    int               cycles;
    logic [7:0]       lfsr_r;
    logic [31:0]      rdata;
    logic             got_err;
    logic             clk_en;
    logic [3:0]       wb_sel_i;
    logic [3:0]       sel_v;

    supply_monitor_ctrl #(.READY_CYCLES(RDY_CYC)) i_dut (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .clk_en          (clk_en),
        .wb_cyc_i        (wb_cyc_i),
        .wb_stb_i        (wb_stb_i),
        .wb_we_i         (wb_we_i),
        .wb_adr_i        (wb_adr_i),
        .wb_sel_i        (wb_sel_i),
        .wb_dat_i        (wb_dat_i),
        .wb_dat_o        (wb_dat_o),
        .wb_ack_o        (wb_ack_o),
        .wb_err_o        (wb_err_o),
        .cmp_below_async (cmp_below_async),
        .cmp_power_on    (cmp_power_on),
        .threshold_sel   (threshold_sel),
        .monitor_irq     (monitor_irq),
        .irq_o           (irq_o)
    );

    // ==========================================================
    // clock, 8 ns period
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // expected control word from its fields
    function automatic logic [31:0] ctrl_word(input logic [3:0] th, input logic [3:0] low);
        return {16'h0000, 4'h0, th, 4'h0, low};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t seen=%08h expected=%08h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // one classic cycle; waits for ack or err, the guard ends a hang
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel_v;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rdata   = wb_dat_o;
        got_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_cycle(1'b1, adr, dat);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0000_0000);
        check(rdata, exp);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        cmp_below_async = 1'b0;
        clk_en = 1'b1;
        wb_sel_i = 4'h0;
        sel_v = 4'hF;
        num_errors = 0;
        tests_run = 0;
        cycles = 0;
        lfsr_r = 8'h25;
        idle(2);
        sys_rst <= 1'b0;
        // reset values
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, 32'h0000_0000);
        rd_chk(supply_monitor_pkg::IRQ_STATUS_ADDR, 32'h0000_0000);
        rd_chk(supply_monitor_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
        check({31'h0, cmp_power_on}, 32'h0000_0000);
        // reserved bits written as zero read zero, bit 4 stores
        wr(supply_monitor_pkg::MON_CTRL_ADDR, 32'h0000_0010);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, 32'h0000_0010);
        wr(supply_monitor_pkg::MON_CTRL_ADDR, 32'h0000_0000);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, 32'h0000_0000);
        // below while disabled is ignored
        cmp_below_async <= 1'b1;
        idle(10);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, 32'h0000_0000);
        cmp_below_async <= 1'b0;
        // random threshold codes while disabled
        for (int i = 0; i < 8; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(lfsr_r[3:0], 4'h0));
            check({28'h0, threshold_sel}, {28'h0, lfsr_r[3:0]});
            rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(lfsr_r[3:0], 4'h0));
        end
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'hF, 4'h0));
        check({28'h0, threshold_sel}, 32'h0000_000F);
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h0));
        // lane 0 alone leaves the threshold code untouched
        sel_v = 4'h1;
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h3, 4'h0));
        sel_v = 4'hF;
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h0));
        // enable, ready only after the power-up delay
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h1));
        check({31'h0, cmp_power_on}, 32'h0000_0001);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h1));
        idle(RDY_CYC + 10);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h3));
        // threshold locked while running
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'hC, 4'h1));
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h3));
        check({28'h0, threshold_sel}, 32'h0000_0007);
        // status, mask and write-one-to-clear
        rd_chk(supply_monitor_pkg::IRQ_STATUS_ADDR, 32'h0000_0002);
        check({31'h0, irq_o}, 32'h0000_0000);
        wr(supply_monitor_pkg::IRQ_MASK_ADDR, 32'h0000_0003);
        idle(2);
        check({31'h0, irq_o}, 32'h0000_0001);
        wr(supply_monitor_pkg::IRQ_STATUS_ADDR, 32'h0000_0002);
        idle(2);
        check({31'h0, irq_o}, 32'h0000_0000);
        rd_chk(supply_monitor_pkg::IRQ_STATUS_ADDR, 32'h0000_0000);
        // undervoltage with interrupt enable off
        cmp_below_async <= 1'b1;
        idle(6);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'hB));
        check({31'h0, monitor_irq}, 32'h0000_0000);
        rd_chk(supply_monitor_pkg::IRQ_STATUS_ADDR, 32'h0000_0001);
        check({31'h0, irq_o}, 32'h0000_0001);
        // clear attempt while still below sets again
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h5));
        idle(2);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'hF));
        check({31'h0, monitor_irq}, 32'h0000_0001);
        // supply recovers, clear sticks
        cmp_below_async <= 1'b0;
        idle(4);
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h5));
        idle(2);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h7));
        check({31'h0, monitor_irq}, 32'h0000_0000);
        wr(supply_monitor_pkg::IRQ_STATUS_ADDR, 32'h0000_0001);
        idle(2);
        check({31'h0, irq_o}, 32'h0000_0000);
        // software set raises the interrupt too
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'hD));
        idle(2);
        check({31'h0, monitor_irq}, 32'h0000_0001);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'hF));
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h5));
        // clock enable low freezes the synchroniser and the flag
        clk_en <= 1'b0;
        cmp_below_async <= 1'b1;
        idle(8);
        check({31'h0, monitor_irq}, 32'h0000_0000);
        clk_en <= 1'b1;
        idle(6);
        check({31'h0, monitor_irq}, 32'h0000_0001);
        check({31'h0, irq_o}, 32'h0000_0001);
        cmp_below_async <= 1'b0;
        idle(4);
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h5));
        // disable stops comparison and drops ready
        wr(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h0));
        check({31'h0, cmp_power_on}, 32'h0000_0000);
        cmp_below_async <= 1'b1;
        idle(8);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h0));
        cmp_below_async <= 1'b0;
        // unmapped place answers with err
        wb_cycle(1'b0, 8'h30, 32'h0000_0000);
        check({31'h0, got_err}, 32'h0000_0001);
        wr(8'h30, 32'h0000_FFFF);
        check({31'h0, got_err}, 32'h0000_0001);
        rd_chk(supply_monitor_pkg::MON_CTRL_ADDR, ctrl_word(4'h7, 4'h0));
        idle(2);
        report_and_stop();
    end

endmodule
